/* File: rtl/frs_pkg.sv */
// Shared constants and types of the result status and configure block
package frs_pkg;
  // Clock rate and drive polling window after reset
  localparam int CLK_MHZ      = 100;
  localparam int POLL_WIN_US  = 500;
  localparam int POLL_WIN_CYC = POLL_WIN_US * CLK_MHZ;
  // Opcode low five bits of the commands framed here
  localparam logic [4:0] OPC_MODE   = 5'h01;
  localparam logic [4:0] OPC_RTRACK = 5'h02;
  localparam logic [4:0] OPC_SPEC   = 5'h03;
  localparam logic [4:0] OPC_SDRV   = 5'h04;
  localparam logic [4:0] OPC_WRITE  = 5'h05;
  localparam logic [4:0] OPC_READ   = 5'h06;
  localparam logic [4:0] OPC_RECAL  = 5'h07;
  localparam logic [4:0] OPC_SINT   = 5'h08;
  localparam logic [4:0] OPC_WRDEL  = 5'h09;
  localparam logic [4:0] OPC_READID = 5'h0A;
  localparam logic [4:0] OPC_RDDEL  = 5'h0C;
  localparam logic [4:0] OPC_FORMAT = 5'h0D;
  localparam logic [4:0] OPC_SEEK   = 5'h0F;
  localparam logic [4:0] OPC_SCANEQ = 5'h11;
  localparam logic [4:0] OPC_PERP   = 5'h12;
  localparam logic [4:0] OPC_VERIFY = 5'h16;
  localparam logic [4:0] OPC_SCANLO = 5'h19;
  localparam logic [4:0] OPC_SCANHI = 5'h1D;
  // Opcode bytes checked in full; lock checks only its low seven bits
  localparam logic [7:0] OPB_CONF   = 8'h13;
  localparam logic [7:0] OPB_DUMP   = 8'h0E;
  localparam logic [6:0] OPB_LOCK   = 7'h14;
  localparam int         LOCK_BIT   = 7;
  // Configure byte field positions
  localparam int CFG_EIS  = 6;
  localparam int CFG_FIFO = 5;
  localparam int CFG_POLL = 4;
  // Values after reset
  localparam logic       RST_EIS      = 1'h0;
  localparam logic       RST_FIFO_OFF = 1'h1;
  localparam logic       RST_POLL_OFF = 1'h0;
  localparam logic [3:0] RST_FIFO_TRIGGER_LEVEL   = 4'h0;
  localparam logic [7:0] RST_PRECOMP_START_CYL   = 8'h00;
  // Termination codes and the invalid opcode answer
  localparam logic [1:0] END_NORMAL  = 2'h0;
  localparam logic [1:0] END_FAIL    = 2'h1;
  localparam logic [1:0] END_INVALID = 2'h2;
  localparam logic [1:0] END_POLL    = 2'h3;
  localparam logic [7:0] INVALID_STATUS = 8'h80;
  localparam logic [7:0] BAD_CYL_MARK   = 8'hFF;
  // Result lengths in bytes
  localparam logic [3:0] RES_DATA = 4'h7;
  localparam logic [3:0] RES_DUMP = 4'hA;
  localparam logic [3:0] RES_SINT = 4'h2;
  localparam logic [3:0] RES_ONE  = 4'h1;
  // Disk event bit positions
  localparam int EV_LAST_BYTE = 0;
  localparam int EV_CRC_ADDR  = 1;
  localparam int EV_CRC_DATA  = 2;
  localparam int EV_SECT_ABS  = 3;
  localparam int EV_RID_FAIL  = 4;
  localparam int EV_START_MIS = 5;
  localparam int EV_NO_IDAM   = 6;
  localparam int EV_NO_DAM    = 7;
  localparam int EV_DEL_MIS   = 8;
  localparam int EV_NOT_FOUND = 9;
  localparam int EV_SCAN_EQ   = 10;
  localparam int EV_SCAN_UN   = 11;
  localparam int EV_SEEK_DONE = 12;
  localparam int EV_NO_CYL_ZERO_PIN   = 13;
  localparam int EV_READY_CHG = 14;
  localparam int EV_W         = 15;
  // Command phase states, one-hot
  typedef enum logic [3:0] {
    S_IDLE   = 4'h1,
    S_PARAM  = 4'h2,
    S_EXEC   = 4'h4,
    S_RESULT = 4'h8
  } frs_state_t;
  // Command kinds, which decide framing and result layout
  typedef enum logic [7:0] {
    K_DATA  = 8'h01,
    K_NORES = 8'h02,
    K_SINT  = 8'h04,
    K_SDRV  = 8'h08,
    K_CONF  = 8'h10,
    K_DUMP  = 8'h20,
    K_LOCK  = 8'h40,
    K_INVAL = 8'h80
  } frs_kind_t;
endpackage

/* File: rtl/frs_flag_if.sv */
// Interface between the command framer and the status flag collector
`timescale 1ns/1ps
`default_nettype none
interface frs_flag_if
  import frs_pkg::*;
  ();
  logic            clear;      // New command starts
  logic [EV_W-1:0] ev;         // Disk event pulses
  logic            protect;    // Write refused on protected media
  logic            count_done; // Terminal count level
  logic [7:0]      rec_cyl;    // Cylinder read from a sector header
  logic [7:0]      cmd_cyl;    // Cylinder given in the command
  logic [7:0]      st_b;       // Second status byte
  logic [7:0]      st_c;       // Third status byte
  modport ctl (output clear, ev, protect, count_done, rec_cyl, cmd_cyl,
               input st_b, st_c);
  modport flg (input clear, ev, protect, count_done, rec_cyl, cmd_cyl,
               output st_b, st_c);
endinterface
`default_nettype wire

/* File: rtl/frs_status_flags.sv */
// Sticky error flags of the second and third status bytes
`timescale 1ns/1ps
`default_nettype none
module frs_status_flags
  import frs_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  frs_flag_if.flg  f
);
  logic [7:0] b_q;   // Second status byte
  logic [7:0] c_q;   // Third status byte
  wire  [7:0] b_set; // Bits raised this cycle
  wire  [7:0] c_set;
  wire        wrong; // Header cylinder differs from command
  wire        bad;   // Header carries the bad cylinder mark

  assign wrong = f.ev[EV_NOT_FOUND] & (f.rec_cyl != f.cmd_cyl);
  assign bad   = wrong & (f.rec_cyl == BAD_CYL_MARK);
  // Second byte: unused D6, D4 and D3 stay 0
  assign b_set = {f.ev[EV_LAST_BYTE] & ~f.count_done,
                  1'h0,
                  f.ev[EV_CRC_ADDR] | f.ev[EV_CRC_DATA],
                  1'h0,
                  1'h0,
                  f.ev[EV_SECT_ABS] | f.ev[EV_RID_FAIL]
                    | f.ev[EV_START_MIS],
                  f.protect,
                  f.ev[EV_NO_IDAM] | f.ev[EV_NO_DAM]};
  // Third byte: unused D7 stays 0
  assign c_set = {1'h0,
                  f.ev[EV_DEL_MIS],
                  f.ev[EV_CRC_DATA],
                  wrong,
                  f.ev[EV_SCAN_EQ],
                  f.ev[EV_SCAN_UN],
                  bad,
                  f.ev[EV_NO_DAM]};
  assign f.st_b = b_q;
  assign f.st_c = c_q;

  // Set wins over the clear at the start of a command
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      b_q <= 8'h00;
      c_q <= 8'h00;
    end else begin
      b_q <= (f.clear ? 8'h00 : b_q) | b_set;
      c_q <= (f.clear ? 8'h00 : c_q) | c_set;
    end
  end
endmodule // frs_status_flags
`default_nettype wire

/* File: rtl/frs_op_decode.sv */
// Opcode decoder: kind, parameter count and command classes
`timescale 1ns/1ps
`default_nettype none
module frs_op_decode
  import frs_pkg::*;
(
  input  wire logic [7:0] opcode,
  output frs_kind_t       kind,
  output logic [3:0]      nparam,
  output logic            rw_class,
  output logic            wr_class
);
  wire [4:0] low = opcode[4:0];      // Code without option bits
  wire conf = (opcode == OPB_CONF);  // Configure
  wire dump = (opcode == OPB_DUMP);  // Register dump
  wire lock = (opcode[6:0] == OPB_LOCK); // Lock, value in bit 7
  wire p1   = low inside {OPC_SDRV, OPC_RECAL, OPC_READID, OPC_PERP};
  wire p2   = low inside {OPC_SPEC, OPC_SEEK};
  wire data = low inside {OPC_RTRACK, OPC_WRITE, OPC_READ, OPC_WRDEL,
                          OPC_READID, OPC_RDDEL, OPC_FORMAT, OPC_SCANEQ,
                          OPC_VERIFY, OPC_SCANLO, OPC_SCANHI};
  wire nres = low inside {OPC_SPEC, OPC_RECAL, OPC_SEEK, OPC_PERP,
                          OPC_MODE};

  // Kind of command, unknown bytes fall to invalid
  assign kind = dump ? K_DUMP :
                conf ? K_CONF :
                lock ? K_LOCK :
                (low == OPC_SINT) ? K_SINT :
                (low == OPC_SDRV) ? K_SDRV :
                data ? K_DATA :
                nres ? K_NORES : K_INVAL;
  // Bytes to collect after the opcode
  assign nparam = (conf | dump | lock) ? (conf ? 4'h3 : 4'h0) :
                  (low == OPC_SINT) ? 4'h0 :
                  p1 ? 4'h1 :
                  p2 ? 4'h2 :
                  (low == OPC_MODE) ? 4'h4 :
                  (low == OPC_FORMAT) ? 4'h5 : 4'h8;
  // Commands that may take an implied seek first
  assign rw_class = low inside {OPC_WRITE, OPC_READ, OPC_WRDEL, OPC_RDDEL,
                                OPC_SCANEQ, OPC_SCANLO, OPC_SCANHI,
                                OPC_VERIFY};
  // Commands that write the media
  assign wr_class = low inside {OPC_WRITE, OPC_WRDEL, OPC_FORMAT};
endmodule // frs_op_decode
`default_nettype wire

/* File: rtl/frs_result_cfg.sv */
// Command framing, result status bytes and configure settings
`timescale 1ns/1ps
`default_nettype none
module frs_result_cfg
  import frs_pkg::*;
#(
  parameter int POLL_WIN_CYCLES = POLL_WIN_CYC // Polling window length
)(
  input  wire logic            clk,
  input  wire logic            reset_n,
  input  wire logic            soft_reset,
  input  wire logic            wr_strobe,
  input  wire logic [7:0]      wr_data,
  input  wire logic            rd_strobe,
  output logic      [7:0]      rd_data_q,
  output logic                 rqm_q,
  output logic                 dio_q,
  output logic                 exec_start_q,
  output logic                 seek_first_q,
  output logic      [7:0]      exec_opcode_q,
  output logic      [63:0]     exec_param,
  input  wire logic            exec_done,
  input  wire logic            exec_fail,
  input  wire logic [EV_W-1:0] disk_ev,
  input  wire logic [7:0]      rec_cyl,
  input  wire logic [1:0]      poll_unit,
  input  wire logic            count_done_pin,
  input  wire logic            write_protect,
  input  wire logic            cyl_zero_pin,
  input  wire logic            side_pin,
  input  wire logic [1:0]      unit_sel,
  input  wire logic            mode_auto_seek,
  input  wire logic [31:0]     id_bytes,
  input  wire logic [31:0]     present_cyl_store,
  input  wire logic [15:0]     spec_timing,
  input  wire logic [7:0]      track_param,
  input  wire logic [5:0]      perp_bits,
  output logic                 auto_seek_on_q,
  output logic                 fifo_off_q,
  output logic                 poll_off_q,
  output logic      [3:0]      fifo_trigger_level_q,
  output logic      [7:0]      precomp_start_cyl_q,
  output logic                 lock_q,
  output logic                 poll_start_q
);
  localparam int WIN_W = $clog2(POLL_WIN_CYCLES + 1); // Window counter

  // Refuse a window shorter than one cycle
  if (POLL_WIN_CYCLES < 1) begin : g_chk
    $error("POLL_WIN_CYCLES must be at least 1");
  end

  frs_state_t       state_q;      // Command phase
  frs_state_t       state_d;
  frs_kind_t        kind_q;       // Kind of current command
  frs_kind_t        dec_kind;     // Decoded kind of incoming opcode
  logic [3:0]       dec_nparam;   // Decoded parameter count
  logic             dec_rw;       // Decoded implied seek class
  logic             dec_wr;       // Decoded media write class
  logic [3:0]       nparam_q;     // Parameters expected
  logic [3:0]       pcnt_q;       // Parameters received
  logic [3:0]       rcnt_q;       // Result bytes read
  logic             rw_q;         // Current command may seek first
  logic             wr_q;         // Current command writes media
  logic [7:0]       par_q [0:7];  // Parameter bytes
  logic [1:0]       code_q;       // Termination code
  logic             side_q;       // Side at end of execution
  logic [1:0]       unit_q;       // Drive at end of execution
  logic [WIN_W-1:0] win_q;        // Cycles left in polling window
  logic             int_pend_q;   // Sense interrupt status pending
  logic [1:0]       int_code_q;   // Pending termination code
  logic             int_se_q;     // Pending seek end
  logic             int_ec_q;     // Pending equipment fault
  logic [1:0]       int_unit_q;   // Pending drive
  frs_flag_if       fl ();        // Flag collector link

  wire       host_wr;   // Accepted command byte
  wire       host_rd;   // Accepted result read
  wire       op_acc;    // Opcode accepted
  wire       frame_now; // Last command byte accepted
  frs_kind_t fk;        // Kind of command being framed
  wire       prot_fail; // Write command on protected media
  wire       to_exec;   // Command moves to execution
  wire [3:0] rlen;      // Result length of current kind
  wire [7:0] st0;       // First status byte
  wire [7:0] st3;       // Drive status byte
  wire [7:0] sint_st0;  // First byte for sense interrupt
  wire [7:0] cfg_byte;  // Configure settings as dumped
  wire [7:0] data_tab [0:6]; // Data command results
  wire [7:0] dump_tab [0:9]; // Register dump results
  wire [7:0] res_byte;  // Selected result byte

  frs_op_decode u_dec (
    .opcode   (wr_data),
    .kind     (dec_kind),
    .nparam   (dec_nparam),
    .rw_class (dec_rw),
    .wr_class (dec_wr)
  );

  frs_status_flags u_flags (
    .clk     (clk),
    .reset_n (reset_n),
    .f       (fl.flg)
  );

  // Data port accepts bytes only while ready and direction agree
  assign host_wr   = wr_strobe & rqm_q & ~dio_q;
  assign host_rd   = rd_strobe & rqm_q & dio_q;
  assign op_acc    = host_wr & (state_q == S_IDLE);
  assign fk        = op_acc ? dec_kind : kind_q;
  assign frame_now = (op_acc & (dec_kind != K_INVAL)
                      & (dec_nparam == 4'h0))
                   | (host_wr & (state_q == S_PARAM)
                      & (pcnt_q == nparam_q - 4'h1));
  assign prot_fail = frame_now & (fk == K_DATA) & wr_q
                   & write_protect;
  assign to_exec   = frame_now & ((fk == K_NORES)
                   | ((fk == K_DATA) & ~(wr_q & write_protect)));

  // Flag collector hookup
  assign fl.clear      = op_acc;
  assign fl.ev         = disk_ev;
  assign fl.protect    = prot_fail;
  assign fl.count_done = count_done_pin;
  assign fl.rec_cyl    = rec_cyl;
  assign fl.cmd_cyl    = par_q[1];

  // Parameter bytes out to the execution engine
  for (genvar g = 0; g < 8; g++) begin : g_par
    assign exec_param[g*8 +: 8] = par_q[g];
  end

  // Result byte tables
  assign st0 = {code_q, 2'h0, 1'h0, side_q, unit_q};
  assign sint_st0 = {int_code_q, int_se_q, int_ec_q, 1'h0, side_q,
                     int_unit_q};
  assign st3 = {1'h0, write_protect, 1'h1, cyl_zero_pin, 1'h1,
                par_q[0][2], par_q[0][1:0]};
  assign cfg_byte = {1'h0, auto_seek_on_q, fifo_off_q, poll_off_q,
                     fifo_trigger_level_q};
  assign data_tab[0] = st0;
  assign data_tab[1] = fl.st_b;
  assign data_tab[2] = fl.st_c;
  for (genvar g = 0; g < 4; g++) begin : g_tab
    assign data_tab[3+g] = id_bytes[31-g*8 -: 8];
    assign dump_tab[g]   = present_cyl_store[g*8 +: 8];
  end
  assign dump_tab[4] = spec_timing[15:8];
  assign dump_tab[5] = spec_timing[7:0];
  assign dump_tab[6] = track_param;
  assign dump_tab[7] = {lock_q, 1'h0, perp_bits};
  assign dump_tab[8] = cfg_byte;
  assign dump_tab[9] = precomp_start_cyl_q;

  // Result length and byte selection by command kind
  assign rlen = (kind_q == K_DATA) ? RES_DATA :
                (kind_q == K_DUMP) ? RES_DUMP :
                (kind_q == K_SINT) ? RES_SINT : RES_ONE;
  assign res_byte = (kind_q == K_DUMP) ? dump_tab[rcnt_q] :
                    (kind_q == K_DATA) ? data_tab[rcnt_q[2:0]] :
                    (kind_q == K_SINT) ? ((rcnt_q == 4'h0) ? sint_st0 :
                      present_cyl_store[{int_unit_q, 3'h0} +: 8]) :
                    (kind_q == K_SDRV) ? st3 :
                    (kind_q == K_LOCK) ? {3'h0, lock_q, 4'h0} :
                    INVALID_STATUS;

  // Phase sequencing
  always_comb begin
    state_d = state_q;
    case (state_q)
      S_IDLE: begin
        if (op_acc && dec_kind == K_INVAL) begin
          state_d = S_RESULT;
        end else if (op_acc) begin
          state_d = S_PARAM;
        end
      end
      S_PARAM: begin
        state_d = state_q;
      end
      S_EXEC: begin
        if (exec_done) begin
          state_d = (kind_q == K_DATA) ? S_RESULT : S_IDLE;
        end
      end
      S_RESULT: begin
        if (host_rd && rcnt_q == rlen - 4'h1) begin
          state_d = S_IDLE;
        end
      end
      default: state_d = S_IDLE;
    endcase
    if (frame_now) begin
      state_d = to_exec ? S_EXEC : (fk == K_CONF) ? S_IDLE : S_RESULT;
    end
    if (soft_reset) begin
      state_d = S_IDLE;
    end
  end

  // Phase, handshake and read data
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_q   <= S_IDLE;
      rqm_q     <= 1'h0;
      dio_q     <= 1'h0;
      rd_data_q <= 8'h00;
    end else begin
      state_q   <= state_d;
      // Ready drops a cycle on each result byte so data settles first
      rqm_q     <= (state_d == S_RESULT) ?
                   ((state_q == S_RESULT) & ~host_rd) :
                   ((state_d == S_IDLE) | (state_d == S_PARAM));
      dio_q     <= (state_d == S_RESULT);
      rd_data_q <= res_byte;
    end
  end

  // Opcode capture and byte counters
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      kind_q        <= K_INVAL;
      exec_opcode_q <= 8'h00;
      nparam_q      <= 4'h0;
      rw_q          <= 1'h0;
      wr_q          <= 1'h0;
      pcnt_q        <= 4'h0;
      rcnt_q        <= 4'h0;
    end else begin
      if (op_acc) begin
        kind_q        <= dec_kind;
        exec_opcode_q <= wr_data;
        nparam_q      <= dec_nparam;
        rw_q          <= dec_rw;
        wr_q          <= dec_wr;
      end
      // Sense interrupt with nothing pending answers as invalid
      if (frame_now && fk == K_SINT && !int_pend_q) begin
        kind_q <= K_INVAL;
      end
      pcnt_q <= op_acc ? 4'h0 : pcnt_q + {3'h0, host_wr};
      rcnt_q <= (state_q == S_RESULT) ? rcnt_q + {3'h0, host_rd} : 4'h0;
    end
  end

  // Parameter byte store
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      for (int i = 0; i < 8; i++) begin
        par_q[i] <= 8'h00;
      end
    end else if (host_wr && state_q == S_PARAM) begin
      par_q[pcnt_q[2:0]] <= wr_data;
    end
  end

  // Execution start and end of execution status
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      exec_start_q <= 1'h0;
      seek_first_q <= 1'h0;
      code_q       <= END_NORMAL;
      side_q       <= 1'h0;
      unit_q       <= 2'h0;
    end else begin
      exec_start_q <= to_exec & ~soft_reset;
      seek_first_q <= to_exec & ~soft_reset & rw_q
                    & (auto_seek_on_q | mode_auto_seek);
      if ((state_q == S_EXEC && exec_done) || prot_fail) begin
        code_q <= (exec_fail | prot_fail) ? END_FAIL : END_NORMAL;
        side_q <= side_pin;
        unit_q <= unit_sel;
      end
    end
  end

  // Configure settings; lock keeps some across software reset
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      auto_seek_on_q       <= RST_EIS;
      fifo_off_q           <= RST_FIFO_OFF;
      poll_off_q           <= RST_POLL_OFF;
      fifo_trigger_level_q <= RST_FIFO_TRIGGER_LEVEL;
      precomp_start_cyl_q  <= RST_PRECOMP_START_CYL;
      lock_q               <= 1'h0;
    end else if (soft_reset) begin
      auto_seek_on_q <= RST_EIS;
      poll_off_q     <= RST_POLL_OFF;
      if (!lock_q) begin
        fifo_off_q           <= RST_FIFO_OFF;
        fifo_trigger_level_q <= RST_FIFO_TRIGGER_LEVEL;
        precomp_start_cyl_q  <= RST_PRECOMP_START_CYL;
      end
    end else if (frame_now && fk == K_CONF) begin
      auto_seek_on_q       <= par_q[1][CFG_EIS];
      fifo_off_q           <= par_q[1][CFG_FIFO];
      poll_off_q           <= par_q[1][CFG_POLL];
      fifo_trigger_level_q <= par_q[1][3:0];
      precomp_start_cyl_q  <= wr_data;
    end else if (frame_now && fk == K_LOCK) begin
      lock_q <= wr_data[LOCK_BIT];
    end
  end

  // Polling window after either reset; polling starts at its end
  always_ff @(posedge clk) begin
    if (!reset_n || soft_reset) begin
      win_q        <= WIN_W'(POLL_WIN_CYCLES);
      poll_start_q <= 1'h0;
    end else begin
      win_q        <= (win_q != '0) ? win_q - 1'b1 : win_q;
      poll_start_q <= (win_q == WIN_W'(1)) & ~poll_off_q;
    end
  end

  // Pending sense interrupt status; a new event wins over the clear
  always_ff @(posedge clk) begin
    if (!reset_n || soft_reset) begin
      int_pend_q <= 1'h0;
      int_code_q <= END_NORMAL;
      int_se_q   <= 1'h0;
      int_ec_q   <= 1'h0;
      int_unit_q <= 2'h0;
    end else if (disk_ev[EV_SEEK_DONE]) begin
      int_pend_q <= 1'h1;
      int_code_q <= disk_ev[EV_NO_CYL_ZERO_PIN] ? END_FAIL : END_NORMAL;
      int_se_q   <= 1'h1;
      int_ec_q   <= disk_ev[EV_NO_CYL_ZERO_PIN];
      int_unit_q <= par_q[0][1:0];
    end else if (disk_ev[EV_READY_CHG] && !poll_off_q) begin
      int_pend_q <= 1'h1;
      int_code_q <= END_POLL;
      int_se_q   <= 1'h0;
      int_ec_q   <= 1'h0;
      int_unit_q <= poll_unit;
    end else if (frame_now && fk == K_SINT) begin
      int_pend_q <= 1'h0;
    end
  end
endmodule // frs_result_cfg
`default_nettype wire

/* File: test/frs_result_cfg_chk.sv */
// Port checks of the result status and configure block
`timescale 1ns/1ps
`default_nettype none
module frs_result_cfg_chk
  import frs_pkg::*;
(
  input wire logic       clk, reset_n, soft_reset, lock_q, dio_q,
  input wire logic       exec_start_q, seek_first_q, mode_auto_seek,
  input wire logic       auto_seek_on_q, fifo_off_q, poll_off_q,
  input wire logic [3:0] fifo_trigger_level_q,
  input wire logic [7:0] precomp_start_cyl_q
);
  // One clock domain; checks rest during hardware reset
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_lock_keeps: assert property (soft_reset && lock_q |=>
    $stable({fifo_off_q, fifo_trigger_level_q, precomp_start_cyl_q}))
    else $error("locked value lost");
  a_unlock_fifo: assert property (soft_reset && !lock_q |=> fifo_off_q)
    else $error("fifo kept");
  a_unlock_zero: assert property (soft_reset && !lock_q |=>
    {fifo_trigger_level_q, precomp_start_cyl_q} == 12'h000)
    else $error("value kept");
  a_soft_modes: assert property (soft_reset |=>
    !auto_seek_on_q && !poll_off_q) else $error("mode kept");
  a_lock_sticky: assert property (soft_reset |=> $stable(lock_q))
    else $error("lock lost");
  a_seek_cause: assert property (seek_first_q |-> exec_start_q &&
    (auto_seek_on_q || mode_auto_seek)) else $error("stray seek");
  a_start_pulse: assert property (exec_start_q |=> !exec_start_q)
    else $error("long start");
  a_start_dir: assert property (exec_start_q |-> !dio_q)
    else $error("start in result");
  c_start: cover property (exec_start_q);
  c_seek: cover property (seek_first_q);
  c_locked: cover property (soft_reset && lock_q);
  c_unlocked: cover property (soft_reset && !lock_q);
endmodule // frs_result_cfg_chk
bind frs_result_cfg frs_result_cfg_chk i_chk (.*);
`default_nettype wire

/* File: test/frs_host.sv */
// Host model driving the command and result data port
`timescale 1ns/1ps
`default_nettype none
module frs_host (
  input  wire logic  clk, rqm_q, dio_q,
  output logic       wr_strobe, rd_strobe,
  output logic [7:0] wr_data
);
  initial {wr_strobe, rd_strobe, wr_data} = 10'h000;
  // Wait for ready in the wanted direction, then strobe over one edge
  task automatic xfer(input logic rd, input logic [7:0] b);
    int n;
    n = 0;
    @(negedge clk);
    while (!(rqm_q && dio_q == rd) && n < 300) begin
      n++;
      @(negedge clk);
    end
    {rd_strobe, wr_strobe, wr_data} = {rd, !rd, b};
    @(negedge clk) {rd_strobe, wr_strobe} = 2'h0;
  endtask
endmodule // frs_host
`default_nettype wire

/* File: test/tb.sv */
// Self-checking bench of the result status and configure block
`timescale 1ns/1ps
`default_nettype none
module tb
  import frs_pkg::*;
;
  logic clk, reset_n, soft_reset, exec_done, exec_fail, count_done_pin;
  logic write_protect, cyl_zero_pin, side_pin, mode_auto_seek, lock_q;
  logic wr_strobe, rd_strobe, rqm_q, dio_q, exec_start_q, seek_first_q;
  logic poll_start_q;
  logic [7:0] exec_opcode_q;
  logic [63:0] exec_param;
  logic auto_seek_on_q, fifo_off_q, poll_off_q;
  logic [1:0] poll_unit, unit_sel;
  logic [3:0] fifo_trigger_level_q;
  logic [5:0] perp_bits;
  logic [7:0] wr_data, rd_data_q, rec_cyl, track_param, precomp_start_cyl_q;
  logic [7:0] q[$];
  logic [15:0] spec_timing;
  logic [31:0] id_bytes, present_cyl_store;
  logic [EV_W-1:0] disk_ev;
  logic [79:0] dump; // Expected dump bytes, first byte lowest
  int error_cnt, total_checks, polls;
  frs_result_cfg #(.POLL_WIN_CYCLES(20)) i_dut (.*);
  frs_host i_host (.*);
  task automatic chk(input string n, input logic [7:0] s, e);
    total_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("unexpected %s exp %h seen %h", n, e, s);
    end
  endtask
  // Note the expected byte, then read it through the host
  task automatic rd(input logic [7:0] e);
    q.push_back(e);
    i_host.xfer(1'b1, 8'h00);
  endtask
  // Data command on drive 2 head 1; a zero event set means no execution
  task automatic cmd(input logic [4:0] op, input logic [EV_W-1:0] ev,
                     input logic [7:0] s0, s1);
    i_host.xfer(1'b0, {3'h0, op});
    i_host.xfer(1'b0, 8'h06);
    repeat (7) i_host.xfer(1'b0, 8'($urandom));
    for (int n = 0; n < 99 && ev != 0 && exec_start_q !== 1'b1; n++)
      @(negedge clk);
    if (ev != 0) begin
      chk("opcode", exec_opcode_q, {3'h0, op});
      chk("param", exec_param[7:0], 8'h06);
      chk("seek", {7'h00, seek_first_q}, {7'h00, mode_auto_seek});
      disk_ev = ev;
      @(negedge clk) {disk_ev, exec_done} = {{EV_W{1'b0}}, 1'b1};
      @(negedge clk) exec_done = 1'b0;
    end
    rd(s0);
    rd(s1);
    rd(8'h00);
    for (int i = 3; i >= 0; i--) rd(id_bytes[8*i+:8]);
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Each accepted result read takes the oldest noted byte
  always @(posedge clk) if (rd_strobe && rqm_q && dio_q && q.size() > 0)
    chk("result", rd_data_q, q.pop_front());
  // Count polling starts at the end of each polling window
  always @(posedge clk) if (poll_start_q === 1'b1) polls++;
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #100000 error_cnt++;
    test_done();
  end
  initial begin
    void'($urandom(32'h100A));
    {reset_n, exec_done, exec_fail, count_done_pin, write_protect} = 5'h00;
    {soft_reset, side_pin, unit_sel, mode_auto_seek, disk_ev} = 20'hE0000;
    {id_bytes, dump} = {$urandom, $urandom, $urandom, 16'($urandom)};
    {spec_timing, track_param, perp_bits} = 30'($urandom);
    {rec_cyl, poll_unit, cyl_zero_pin} = 11'($urandom);
    dump[63:32] = {2'h0, perp_bits, track_param, spec_timing[7:0],
                   spec_timing[15:8]};
    dump[71:64] = {4'h5, dump[67:64]};
    present_cyl_store = dump[31:0];
    repeat (5) @(negedge clk);
    reset_n = 1'b1;
    @(negedge clk) soft_reset = 1'b0;
    chk("fifo_off", {7'h00, fifo_off_q}, 8'h01);
    i_host.xfer(1'b0, 8'h1F);
    rd(INVALID_STATUS);
    i_host.xfer(1'b0, OPB_CONF);
    for (int i = 7; i < 10; i++) i_host.xfer(1'b0, dump[8*i+:8]);
    i_host.xfer(1'b0, OPB_DUMP);
    for (int i = 0; i < 10; i++) rd(dump[8*i+:8]);
    i_host.xfer(1'b0, 8'h94);
    rd(8'h10);
    soft_reset = 1'b1;
    @(negedge clk) soft_reset = 1'b0;
    @(negedge clk);
    chk("fifo_trigger_level", {4'h0, fifo_trigger_level_q}, 8'(dump[67:64]));
    chk("precomp", precomp_start_cyl_q, dump[79:72]);
    write_protect = 1'b1;
    cmd(OPC_WRITE, '0, 8'h46, 8'h02);
    {write_protect, mode_auto_seek} = 2'h1;
    cmd(OPC_READ, 15'h0001, 8'h06, 8'h80);
    // Ready change while polling is on, then a sense interrupt
    disk_ev[EV_READY_CHG] = 1'b1;
    @(negedge clk) disk_ev = '0;
    i_host.xfer(1'b0, 8'h08);
    rd({END_POLL, 4'h1, poll_unit});
    rd(present_cyl_store[8*poll_unit+:8]);
    repeat (4) @(negedge clk);
    chk("queue", 8'(q.size()), 8'h00);
    chk("polls", 8'(polls), 8'h01);
    test_done();
  end
endmodule // tb
`default_nettype wire
